//--- pkg/tq_cfg.svh
// Constants for the timer core: offsets, fields, reset values, widths
`ifndef TQ_CFG_SVH
`define TQ_CFG_SVH

`define TQ_CNT_W 16
`define TQ_CNT_IDLE 16'hFFFF
`define TQ_CNT_ZERO 16'h0000
`define TQ_CC_RST 16'h0000
`define TQ_REG8_RST 8'h00
`define TQ_NUM_CC 4
`define TQ_NUM_IN 5
`define TQ_EVT_IDX 4
`define TQ_EDGE_W 10
`define TQ_PRE_W 7
`define TQ_PRE_ONE 7'h01
`define TQ_BYTES 4
`define TQ_BYTE_W 8
`define TQ_ADDR_W 8
`define TQ_DATA_W 32
`define TQ_WORD_ZERO 32'h0000_0000

`define TQ_OFS_CTL0 8'h00
`define TQ_OFS_MODE 8'h04
`define TQ_OFS_CNT 8'h08
`define TQ_OFS_CC0 8'h10
`define TQ_CC_STRIDE 8'h04
`define TQ_OFS_EDGE_A 8'h20
`define TQ_OFS_EDGE_B 8'h24
`define TQ_OFS_OUT0 8'h28
`define TQ_OFS_OUT1 8'h2C
`define TQ_OFS_STAT 8'h30
`define TQ_OFS_MASK 8'h34

`define TQ_CTL0_CE 7
`define TQ_CTL0_WMASK 8'h87
`define TQ_CKS_HI 2
`define TQ_MODE_EXT 0
`define TQ_MODE_PWM 1
`define TQ_MODE_CAP_LO 4
`define TQ_MODE_WMASK 8'hF3
`define TQ_ST_W 9
`define TQ_ST_CAP_LO 4
`define TQ_ST_OVF 8
`define TQ_OC0_POL_LO 4
`define TQ_OC1_EN 0
`define TQ_OC1_POL 1

`define TQ_RESP_OKAY 2'h0
`define TQ_RESP_SLVERR 2'h2

`endif

//--- pkg/tq_pkg.sv
// Types shared by the timer core and its edge detector
package tq_pkg;
  `include "tq_cfg.svh"
  typedef enum logic [1:0] {
    TQ_EDGE_NONE = 2'h0,
    TQ_EDGE_RISE = 2'h1,
    TQ_EDGE_FALL = 2'h2,
    TQ_EDGE_BOTH = 2'h3
  } tq_edge_t;
  typedef logic [`TQ_CNT_W-1:0] tq_count_t;
endpackage

//--- src/tq_edge_det.sv
// Pin synchroniser and selectable edge detector for timer inputs
`timescale 1ns/1ps
`include "tq_cfg.svh"

module tq_edge_det (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`TQ_NUM_IN-1:0] pinIn,
  input wire logic [`TQ_EDGE_W-1:0] edgeMode,
  output logic [`TQ_NUM_IN-1:0] edgePulse
);
  logic [`TQ_NUM_IN-1:0] syncA_r, syncB_r, syncC_r, level_r;

  function automatic logic edgeHit(input tq_pkg::tq_edge_t mode,
                                   input logic newLvl);
    case (mode)
      tq_pkg::TQ_EDGE_RISE: return newLvl;
      tq_pkg::TQ_EDGE_FALL: return !newLvl;
      tq_pkg::TQ_EDGE_BOTH: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // First stage feeds only the second stage
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      syncA_r <= '0;
      syncB_r <= '0;
      syncC_r <= '0;
    end
    else
    begin
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      level_r <= '0;
      edgePulse <= '0;
    end
    else
    begin
      for (int i = 0; i < `TQ_NUM_IN; i++)
      begin
        edgePulse[i] <= 1'b0;
        if (syncB_r[i] == syncC_r[i] && syncC_r[i] != level_r[i])
        begin
          level_r[i] <= syncC_r[i];
          edgePulse[i] <= edgeHit(tq_pkg::tq_edge_t'(edgeMode[2*i +: 2]),
                                  syncC_r[i]);
        end
      end
    end
  end
endmodule

//--- src/tq_counter_core.sv
// Timer core: counter, compare buffers, outputs and AXI4-Lite registers
`timescale 1ns/1ps
`include "tq_cfg.svh"

module tq_counter_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`TQ_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [`TQ_DATA_W-1:0] wdata,
  input wire logic [`TQ_BYTES-1:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`TQ_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [`TQ_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire logic captureInputA,
  input wire logic captureInputB,
  input wire logic captureInputC,
  input wire logic captureInputD,
  input wire logic externalEventInput,
  output logic [`TQ_NUM_CC-1:0] ch0TimerOut,
  output logic highSidePwmOutA,
  output logic highSidePwmOutB,
  output logic highSidePwmOutC,
  output logic channelOneOutput,
  output logic matchIrqZero,
  output logic matchIrqOne,
  output logic matchIrqTwo,
  output logic matchIrqThree,
  output logic irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] timerControlZero_r, mode_r, edgeA_r, out0_r;
  logic [1:0] edgeB_r, out1_r;
  logic [`TQ_ST_W-1:0] status_r, mask_r, stSet, stClr;
  tq_pkg::tq_count_t cc_r [0:`TQ_NUM_CC-1];
  tq_pkg::tq_count_t ccBuf_r [0:`TQ_NUM_CC-1];
  tq_pkg::tq_count_t cnt_r;
  logic [`TQ_PRE_W-1:0] pre_r;
  logic started_r, cntUpd_r, awHave_r, wHave_r;
  logic [`TQ_ADDR_W-1:0] awAddr_r;
  logic [`TQ_DATA_W-1:0] wData_r, rdWord, clrWord;
  logic [`TQ_BYTES-1:0] wStrb_r;
  logic [`TQ_NUM_CC-1:0] matchEv, capEv, matchIrq_r, ch0Lvl_r, capMode;
  logic [`TQ_NUM_IN-1:0] edgePulse;
  logic [2:0] highSide_r;
  logic ch1Lvl_r, ce, extSel, pwm, intTick, countTick, ovfEv;
  logic awHs, wHs, arHs, doWrite;

  assign ce = timerControlZero_r[`TQ_CTL0_CE];
  assign extSel = mode_r[`TQ_MODE_EXT];
  assign pwm = mode_r[`TQ_MODE_PWM];
  assign capMode = mode_r[`TQ_MODE_CAP_LO +: `TQ_NUM_CC];
  assign awHs = awvalid && awready;
  assign wHs = wvalid && wready;
  assign arHs = arvalid && arready;
  assign doWrite = awHave_r && wHave_r && !bvalid;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`TQ_DATA_W-1:0] mergeBytes(
    input logic [`TQ_DATA_W-1:0] old,
    input logic [`TQ_DATA_W-1:0] dat,
    input logic [`TQ_BYTES-1:0] strb);
    logic [`TQ_DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < `TQ_BYTES; i++)
      if (strb[i])
        res[i*`TQ_BYTE_W +: `TQ_BYTE_W] = dat[i*`TQ_BYTE_W +: `TQ_BYTE_W];
    return res;
  endfunction

  function automatic logic [`TQ_ADDR_W-1:0] ccAddr(input int k);
    return `TQ_OFS_CC0 + `TQ_ADDR_W'(k) * `TQ_CC_STRIDE;
  endfunction

  function automatic logic isMapped(input logic [`TQ_ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      `TQ_OFS_CTL0, `TQ_OFS_MODE, `TQ_OFS_CNT, `TQ_OFS_EDGE_A,
      `TQ_OFS_EDGE_B, `TQ_OFS_OUT0, `TQ_OFS_OUT1, `TQ_OFS_STAT,
      `TQ_OFS_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    for (int k = 0; k < `TQ_NUM_CC; k++)
      if (a == ccAddr(k))
        hit = 1'b1;
    return hit;
  endfunction

  // Divider taps: every cycle, then every 2 up to every 128
  function automatic logic divTick(input logic [`TQ_PRE_W-1:0] pre,
                                   input logic [`TQ_CKS_HI:0] sel);
    logic [`TQ_PRE_W-1:0] m;
    m = (`TQ_PRE_ONE << sel) - `TQ_PRE_ONE;
    return (pre & m) == m;
  endfunction

  // ----------------------------------------------------------------
  // Inputs
  // ----------------------------------------------------------------
  tq_edge_det u_edge (
    .mclk(mclk),
    .rst(rst),
    .pinIn({externalEventInput, captureInputD, captureInputC,
            captureInputB, captureInputA}),
    .edgeMode({edgeB_r, edgeA_r}),
    .edgePulse(edgePulse)
  );

  // ----------------------------------------------------------------
  // Count clock and counter
  // ----------------------------------------------------------------
  assign intTick = divTick(pre_r, timerControlZero_r[`TQ_CKS_HI:0]);
  assign countTick = ce && (extSel ? edgePulse[`TQ_EVT_IDX]
                                   : intTick);
  assign ovfEv = countTick && started_r && cnt_r == `TQ_CNT_IDLE;

  // Divider restarts on enable so the first tick lands at a known point
  always_ff @(posedge mclk)
  begin
    if (rst || !ce)
      pre_r <= '0;
    else
      pre_r <= pre_r + `TQ_PRE_ONE;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || !ce)
    begin
      cnt_r <= `TQ_CNT_IDLE;
      started_r <= 1'b0;
      cntUpd_r <= 1'b0;
    end
    else
    begin
      cntUpd_r <= countTick;
      if (countTick)
      begin
        started_r <= 1'b1;
        if (pwm && started_r && cnt_r == ccBuf_r[0])
          cnt_r <= `TQ_CNT_ZERO;
        else
          cnt_r <= cnt_r + `TQ_CNT_W'(1);
      end
    end
  end

  // Compare only on the cycle after the counter moved, one pulse per value
  always_comb
  begin
    for (int k = 0; k < `TQ_NUM_CC; k++)
    begin
      matchEv[k] = ce && cntUpd_r && !capMode[k]
                   && cnt_r == ccBuf_r[k];
      capEv[k] = ce && capMode[k] && edgePulse[k];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      matchIrq_r <= '0;
    else
      matchIrq_r <= matchEv;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      timerControlZero_r <= `TQ_REG8_RST;
      mode_r <= `TQ_REG8_RST;
      edgeA_r <= `TQ_REG8_RST;
      edgeB_r <= '0;
      out0_r <= `TQ_REG8_RST;
      out1_r <= '0;
      mask_r <= '0;
    end
    else if (doWrite)
    begin
      case (awAddr_r)
        // Same-value rewrite leaves enable and counter untouched
        `TQ_OFS_CTL0: timerControlZero_r <= 8'(mergeBytes(
          {24'h00_0000, timerControlZero_r}, wData_r, wStrb_r))
          & `TQ_CTL0_WMASK;
        `TQ_OFS_MODE: mode_r <= 8'(mergeBytes({24'h00_0000, mode_r},
          wData_r, wStrb_r)) & `TQ_MODE_WMASK;
        `TQ_OFS_EDGE_A: edgeA_r <= 8'(mergeBytes({24'h00_0000, edgeA_r},
          wData_r, wStrb_r));
        `TQ_OFS_EDGE_B: edgeB_r <= 2'(mergeBytes({30'h0000_0000, edgeB_r},
          wData_r, wStrb_r));
        `TQ_OFS_OUT0: out0_r <= 8'(mergeBytes({24'h00_0000, out0_r},
          wData_r, wStrb_r));
        `TQ_OFS_OUT1: out1_r <= 2'(mergeBytes({30'h0000_0000, out1_r},
          wData_r, wStrb_r));
        `TQ_OFS_MASK: mask_r <= `TQ_ST_W'(mergeBytes({23'h00_0000, mask_r},
          wData_r, wStrb_r));
        default: mask_r <= mask_r;
      endcase
    end
  end

  // Capture wins over a software write landing in the same cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int k = 0; k < `TQ_NUM_CC; k++)
        cc_r[k] <= `TQ_CC_RST;
    end
    else
    begin
      for (int k = 0; k < `TQ_NUM_CC; k++)
        if (capEv[k])
          cc_r[k] <= ce ? cnt_r : `TQ_CNT_ZERO;
        else if (doWrite && awAddr_r == ccAddr(k))
          cc_r[k] <= `TQ_CNT_W'(mergeBytes({16'h0000, cc_r[k]}, wData_r,
                                wStrb_r));
    end
  end

  // Buffers have no address of their own
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int k = 0; k < `TQ_NUM_CC; k++)
        ccBuf_r[k] <= `TQ_CC_RST;
    end
    else
    begin
      for (int k = 0; k < `TQ_NUM_CC; k++)
        if (doWrite && awAddr_r == ccAddr(k) && !capMode[k])
          ccBuf_r[k] <= `TQ_CNT_W'(mergeBytes({16'h0000, cc_r[k]}, wData_r,
                                   wStrb_r));
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  assign stSet = {ovfEv, capEv, matchEv};
  assign clrWord = mergeBytes(`TQ_WORD_ZERO, wData_r, wStrb_r);
  assign stClr = (doWrite && awAddr_r == `TQ_OFS_STAT)
                 ? clrWord[`TQ_ST_W-1:0] : '0;

  // New events win over a write-one clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      status_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status_r <= (status_r & ~stClr) | stSet;
      irq <= |(status_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Output controller
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst || !ce)
    begin
      ch0Lvl_r <= '0;
      ch1Lvl_r <= 1'b0;
    end
    else
    begin
      ch0Lvl_r[0] <= ch0Lvl_r[0] ^ matchEv[0];
      for (int k = 1; k < `TQ_NUM_CC; k++)
        if (pwm)
          ch0Lvl_r[k] <= (ch0Lvl_r[k] || matchEv[0]) && !matchEv[k];
        else
          ch0Lvl_r[k] <= ch0Lvl_r[k] ^ matchEv[k];
      ch1Lvl_r <= ch1Lvl_r ^ matchEv[0];
    end
  end

  // Pins lag the level by one cycle so every output is a flop
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ch0TimerOut <= '0;
      highSide_r <= '0;
      channelOneOutput <= 1'b0;
    end
    else
    begin
      ch0TimerOut <= (ch0Lvl_r ^ out0_r[`TQ_OC0_POL_LO +: `TQ_NUM_CC])
                     & out0_r[`TQ_NUM_CC-1:0];
      highSide_r <= pwm ? ~(ch0Lvl_r[`TQ_NUM_CC-1:1]
                     ^ out0_r[`TQ_OC0_POL_LO+1 +: 3])
                     & out0_r[`TQ_NUM_CC-1:1] : '0;
      channelOneOutput <= (ch1Lvl_r ^ out1_r[`TQ_OC1_POL])
                          && out1_r[`TQ_OC1_EN];
    end
  end

  assign highSidePwmOutA = highSide_r[0];
  assign highSidePwmOutB = highSide_r[1];
  assign highSidePwmOutC = highSide_r[2];
  assign matchIrqZero = matchIrq_r[0];
  assign matchIrqOne = matchIrq_r[1];
  assign matchIrqTwo = matchIrq_r[2];
  assign matchIrqThree = matchIrq_r[3];

  // ----------------------------------------------------------------
  // AXI4-Lite write path, one write in flight
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      awready <= 1'b0;
      awHave_r <= 1'b0;
      awAddr_r <= '0;
      wready <= 1'b0;
      wHave_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end
    else
    begin
      awready <= !awHs && !awHave_r && !bvalid;
      wready <= !wHs && !wHave_r && !bvalid;
      if (awHs)
      begin
        awHave_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      else if (doWrite)
        awHave_r <= 1'b0;
      if (wHs)
      begin
        wHave_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      else if (doWrite)
        wHave_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp <= `TQ_RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      bresp <= isMapped(awAddr_r) ? `TQ_RESP_OKAY : `TQ_RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rdWord = `TQ_WORD_ZERO;
    case (araddr)
      `TQ_OFS_CTL0: rdWord[7:0] = timerControlZero_r;
      `TQ_OFS_MODE: rdWord[7:0] = mode_r;
      `TQ_OFS_CNT: rdWord[`TQ_CNT_W-1:0] = ce ? cnt_r
                                              : `TQ_CNT_ZERO;
      `TQ_OFS_EDGE_A: rdWord[7:0] = edgeA_r;
      `TQ_OFS_EDGE_B: rdWord[1:0] = edgeB_r;
      `TQ_OFS_OUT0: rdWord[7:0] = out0_r;
      `TQ_OFS_OUT1: rdWord[1:0] = out1_r;
      `TQ_OFS_STAT: rdWord[`TQ_ST_W-1:0] = status_r;
      `TQ_OFS_MASK: rdWord[`TQ_ST_W-1:0] = mask_r;
      default: rdWord = `TQ_WORD_ZERO;
    endcase
    for (int k = 0; k < `TQ_NUM_CC; k++)
      if (araddr == ccAddr(k))
        rdWord[`TQ_CNT_W-1:0] = cc_r[k];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `TQ_RESP_OKAY;
    end
    else
    begin
      arready <= !arHs && !rvalid;
      if (arHs)
      begin
        rvalid <= 1'b1;
        rdata <= rdWord;
        rresp <= isMapped(araddr) ? `TQ_RESP_OKAY : `TQ_RESP_SLVERR;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_IDLE_HOLD: assert property (!ce |=> cnt_r == `TQ_CNT_IDLE)
    else $error("counter not held at idle while disabled");
  AST_RD_ZERO: assert property (arHs && araddr == `TQ_OFS_CNT && !ce
    |=> rvalid && rdata == `TQ_WORD_ZERO)
    else $error("count readback not zero while disabled");
  AST_RESET_OFF: assert property ($fell(rst) |-> !ce && !irq)
    else $error("run enable set after reset");
  AST_BUF_XFER: assert property (doWrite && awAddr_r == `TQ_OFS_CC0
    && wStrb_r == 4'hF && !capMode[0]
    |=> ccBuf_r[0] == $past(wData_r[`TQ_CNT_W-1:0]))
    else $error("compare buffer missed transfer");
  AST_MATCH_IRQ: assert property (cntUpd_r && ce && !capMode[1]
    && cnt_r == ccBuf_r[1] |=> matchIrqOne ##1 !matchIrqOne)
    else $error("match interrupt missing or too long");
  AST_BUF_PRIV: assert property ($changed(ccBuf_r[2])
    |-> $past(doWrite) && $past(awAddr_r) == ccAddr(2))
    else $error("compare buffer changed without a write");
  AST_RESET_CC: assert property ($fell(rst)
    |-> cc_r[0] == `TQ_CC_RST && ccBuf_r[3] == `TQ_CC_RST)
    else $error("compare registers not cleared by reset");
  AST_EDGE_NONE: assert property (edgeB_r == 2'h0 && $past(edgeB_r) == 2'h0
    |-> !edgePulse[`TQ_EVT_IDX])
    else $error("edge seen with detection off");
  AST_CH1_OFF: assert property (!out1_r[`TQ_OC1_EN]
    |=> !channelOneOutput)
    else $error("channel one pin driven while disabled");
  AST_DIV_TAP: assert property (countTick && !extSel
    && timerControlZero_r[`TQ_CKS_HI:0] == 3'h3
    |-> pre_r[2:0] == 3'h7)
    else $error("divided clock tick at wrong phase");
  AST_FIRST_STEP: assert property (countTick && !started_r
    |=> cnt_r == `TQ_CNT_ZERO
    ##1 cnt_r == `TQ_CNT_ZERO + `TQ_CNT_W'($past(countTick)))
    else $error("first count clock did not yield zero");
  AST_HS_PWM: assert property (!pwm |=> !highSidePwmOutA
    && !highSidePwmOutB && !highSidePwmOutC)
    else $error("high-side pin active outside PWM mode");
  AST_STOP: assert property ($fell(ce) |=> ##1 ch0TimerOut
    == (out0_r[`TQ_OC0_POL_LO +: `TQ_NUM_CC] & out0_r[3:0]))
    else $error("outputs not reset on stop");

  CVR_MATCH: cover property (matchIrqZero);
  CVR_CAPTURE: cover property (capEv[0]);
  CVR_OVERFLOW: cover property (ovfEv);
  CVR_IRQ: cover property ($rose(irq));
endmodule

//--- dv/tq_pin_partner.sv
// Pin-side model driving the capture and event inputs of the timer
`timescale 1ns/1ps

module tq_pin_partner (
  input wire logic mclk,
  output logic captureInputA,
  output logic captureInputB,
  output logic captureInputC,
  output logic captureInputD,
  output logic externalEventInput
);
  initial
  begin
    captureInputA = 1'b0;
    captureInputB = 1'b0;
    captureInputC = 1'b0;
    captureInputD = 1'b0;
    externalEventInput = 1'b0;
  end

  // Each level held 8 clocks so the synchroniser cannot miss it
  task automatic pulse_event(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      externalEventInput <= 1'b1;
      repeat (8) @(posedge mclk);
      externalEventInput <= 1'b0;
      repeat (8) @(posedge mclk);
    end
  endtask

  // One high pulse on the first capture pin
  task automatic pulse_capture;
    @(posedge mclk);
    captureInputA <= 1'b1;
    repeat (8) @(posedge mclk);
    captureInputA <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule

//--- dv/tb_tq_counter_core.sv
// Self-checking bench for the timer core
`timescale 1ns/1ps
`include "tq_cfg.svh"

module tb_tq_counter_core;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, lastResp;
  logic [31:0] rdata;
  logic cA, cB, cC, cD, evt, hA, hB, hC, ch1, m0, m1, m2, m3;
  logic [3:0] ch0;
  int nErrors = 0;
  int compares = 0;
  int nMatchOne = 0;
  int nMatchZero = 0;

  always #20 mclk = ~mclk;

  tq_pin_partner partner (.mclk(mclk), .captureInputA(cA),
    .captureInputB(cB), .captureInputC(cC), .captureInputD(cD),
    .externalEventInput(evt));

  tq_counter_core dut (.mclk(mclk), .rst(rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .captureInputA(cA), .captureInputB(cB), .captureInputC(cC),
    .captureInputD(cD), .externalEventInput(evt), .ch0TimerOut(ch0),
    .highSidePwmOutA(hA), .highSidePwmOutB(hB), .highSidePwmOutC(hC),
    .channelOneOutput(ch1), .matchIrqZero(m0), .matchIrqOne(m1),
    .matchIrqTwo(m2), .matchIrqThree(m3), .irq(irq));

  always @(posedge mclk)
    if (m1 === 1'b1)
      nMatchOne++;

  // Buffers 0, 2 and 3 share a value, so their pulses coincide
  always @(posedge mclk)
    if ({m0, m2, m3} === 3'b111)
      nMatchZero++;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    // Readies are read before this edge's updates land
    while (aw || w)
    begin
      @(posedge mclk);
      if (aw && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    lastResp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    v = rdata;
    lastResp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask

  task automatic t_reset;
    rdc("ctl0 reset", `TQ_OFS_CTL0, 32'h0000_0000);
    rdc("count idle", `TQ_OFS_CNT, 32'h0000_0000);
    rdc("cc0 reset", `TQ_OFS_CC0, 32'h0000_0000);
    rdc("cc3 reset", 8'h1C, 32'h0000_0000);
    rdc("unmapped read", 8'h3C, 32'h0000_0000);
    chk("rresp", {30'h0000_0000, `TQ_RESP_SLVERR}, {30'h0000_0000, lastResp});
    wr(8'h3C, 32'h0000_FFFF);
    chk("bresp", {30'h0000_0000, `TQ_RESP_SLVERR}, {30'h0000_0000, lastResp});
  endtask

  task automatic t_ctl0;
    logic [31:0] v;
    wr(`TQ_OFS_CTL0, 32'h0000_00FF);
    rdc("ctl0 fields", `TQ_OFS_CTL0, 32'h0000_0087);
    // Slowest divider: 300 clocks give at most three ticks
    repeat (300) @(posedge mclk);
    rd(`TQ_OFS_CNT, v);
    chk("slow count", 32'h0000_0001, {31'h0000_0000, v < 4});
    wr(`TQ_OFS_CTL0, 32'h0000_0000);
    rdc("count stopped", `TQ_OFS_CNT, 32'h0000_0000);
  endtask

  task automatic t_compare;
    logic [31:0] v1;
    logic [31:0] v2;
    // Earlier slow run already matched at zero
    nMatchOne = 0;
    nMatchZero = 0;
    wr(8'h14, 32'h0000_0005);
    rdc("cc1 visible", 8'h14, 32'h0000_0005);
    wr(`TQ_OFS_OUT0, 32'h0000_000F);
    wr(`TQ_OFS_OUT1, 32'h0000_0001);
    wr(`TQ_OFS_CTL0, 32'h0000_0080);
    rd(`TQ_OFS_CNT, v1);
    wr(`TQ_OFS_CTL0, 32'h0000_0080);
    rd(`TQ_OFS_CNT, v2);
    chk("count kept", 32'h0000_0001, {31'h0000_0000, v2 > v1});
    chk("match one", 32'h0000_0001, nMatchOne);
    chk("match zero", 32'h0000_0001, nMatchZero);
    chk("ch0 pins", 32'h0000_000F, {28'h000_0000, ch0});
    chk("ch1 pin", 32'h0000_0001, {31'h0000_0000, ch1});
    chk("high side", 32'h0000_0000, {29'h0000_0000, hA, hB, hC});
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    rdc("status", `TQ_OFS_STAT, 32'h0000_000F);
    wr(`TQ_OFS_MASK, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    chk("irq on", 32'h0000_0001, {31'h0000_0000, irq});
    wr(`TQ_OFS_CTL0, 32'h0000_0000);
    wr(`TQ_OFS_STAT, 32'h0000_000F);
    rdc("status clear", `TQ_OFS_STAT, 32'h0000_0000);
    chk("irq off", 32'h0000_0000, {31'h0000_0000, irq});
    rdc("count off", `TQ_OFS_CNT, 32'h0000_0000);
  endtask

  task automatic t_events;
    // Three pin pulses under none, rising, falling and both edges
    logic [31:0] expCnt [4];
    expCnt = '{32'h0000_FFFF, 32'h0000_0002, 32'h0000_0002,
               32'h0000_0005};
    for (int m = 0; m < 4; m++)
    begin
      wr(`TQ_OFS_CTL0, 32'h0000_0000);
      wr(`TQ_OFS_EDGE_B, m);
      wr(`TQ_OFS_MODE, 32'h0000_0001);
      wr(`TQ_OFS_CTL0, 32'h0000_0080);
      partner.pulse_event(3);
      repeat (8) @(posedge mclk);
      rdc("event count", `TQ_OFS_CNT, expCnt[m]);
    end
  endtask

  task automatic t_midreset;
    int n0;
    wr(8'h18, 32'h0000_1234);
    wr(`TQ_OFS_CTL0, 32'h0000_0080);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rdc("cc2 cleared", 8'h18, 32'h0000_0000);
    rdc("ctl0 cleared", `TQ_OFS_CTL0, 32'h0000_0000);
    rdc("count cleared", `TQ_OFS_CNT, 32'h0000_0000);
    // Cleared buffer 2 must match at zero again
    n0 = nMatchZero;
    wr(`TQ_OFS_CTL0, 32'h0000_0080);
    repeat (4) @(posedge mclk);
    wr(`TQ_OFS_CTL0, 32'h0000_0000);
    chk("buffer cleared", n0 + 1, nMatchZero);
  endtask

  task automatic t_capture;
    logic [31:0] v;
    wr(`TQ_OFS_MODE, 32'h0000_0010);
    wr(`TQ_OFS_EDGE_A, 32'h0000_0001);
    wr(`TQ_OFS_STAT, 32'h0000_01FF);
    wr(`TQ_OFS_CTL0, 32'h0000_0080);
    partner.pulse_capture();
    rdc("capture status", `TQ_OFS_STAT, 32'h0000_001E);
    rd(`TQ_OFS_CC0, v);
    chk("captured", 32'h0000_0001, {31'h0000_0000, v != 0});
    wr(`TQ_OFS_CTL0, 32'h0000_0000);
  endtask

  task automatic t_pwm;
    wr(`TQ_OFS_MODE, 32'h0000_0002);
    wr(`TQ_OFS_CC0, 32'h0000_0010);
    wr(8'h14, 32'h0000_0004);
    wr(`TQ_OFS_OUT0, 32'h0000_000F);
    wr(`TQ_OFS_CTL0, 32'h0000_0080);
    // High side is the inverse of its paired pin
    repeat (40)
    begin
      @(negedge mclk);
      chk("high side pwm", {29'h0000_0000, ~ch0[1], ~ch0[2], ~ch0[3]},
          {29'h0000_0000, hA, hB, hC});
    end
    wr(`TQ_OFS_CTL0, 32'h0000_0000);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", nErrors, compares);
    if (nErrors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    nErrors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_ctl0();
    t_compare();
    t_events();
    t_midreset();
    t_capture();
    t_pwm();
    tally_and_finish();
  end
endmodule
